/* File: hdl/interrupt_wakeup_controller.sv */
// Interrupt and wake-up controller: flags, enables, priority, vectors.
// Assumes a CPU core on the register bus that acknowledges requests
// and reports return from service; all inputs synchronous to core_clk.
//
// Function
// - Arbitrate eleven sources, each at one of four priority levels.
// - Any enabled pending source wakes the CPU from Idle while the global enable is set.
// - Only pin sources may wake the CPU from Stop.
// - Source flags set on events regardless of their enable bits.
// - Every source has its own independent enable bit.
// - Service requires permission from the global enable bit and the source's own bit.
// - Level comes from one low-group bit and one high-group bit.
// - Serve a pending source at once unless equal or higher active.
// - Hold a request while an equal or higher level is in service.
// - A higher level preempts a lower level routine at once.
// - After preemption ends, the suspended routine resumes.
// - Pins A, B, C vector to 0003, 0013, 004B with own flags.
// - Port change vectors to 0043 with one flag, wakes from Stop.
// - Timers A, B, C at 000B, 001B, 002B; C from two flags.
// - 0033 reserved for emulation; timer D at 003B.
// - Serial receive or transmit flag requests vector 0023.
// - Convert/touch share 0053; SPI three flags use 005B.
// - Each port pin has its own change enable bit.
// - Code 00 is level 0 lowest, 11 is level 3 highest.
// - Pins A, B edge or level; C falling edge; port any change.
// - Trigger type 0 selects low level, 1 selects falling edge.
// - Enabled pin C wakes from Stop whatever the global enable.
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_cfg.svh"

module interrupt_wakeup_controller #(
    parameter int NUM_SOURCES = 11,
    parameter int PORT_WIDTH  = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic [7:0]            sfrAddr,
    input  wire logic [7:0]            sfrWrData,
    input  wire logic                  sfrWr,
    input  wire logic                  sfrRd,
    output var  logic [7:0]            sfrRdData,
    input  wire logic                  extPinA,
    input  wire logic                  extPinB,
    input  wire logic                  extPinC,
    input  wire logic [PORT_WIDTH-1:0] portPins,
    input  wire logic                  timerAOverflow,
    input  wire logic                  timerBOverflow,
    input  wire logic                  timerCOverflow,
    input  wire logic                  timerCExternalFlag,
    input  wire logic                  timerDOverflow,
    input  wire logic                  uartRxFlag,
    input  wire logic                  uartTxFlag,
    input  wire logic                  adcDoneFlag,
    input  wire logic                  touchDoneFlag,
    input  wire logic                  spiDoneFlag,
    input  wire logic                  spiCollisionFlag,
    input  wire logic                  spiFaultFlag,
    input  wire logic                  idleMode,
    input  wire logic                  stopMode,
    input  wire logic                  irqAck,
    input  wire logic                  irqReturn,
    output var  logic                  irqReq,
    output var  logic [15:0]           irqVector,
    output var  logic                  wakeIdle,
    output var  logic                  wakeStop,
    output var  logic                  flashWriteEn
);

    localparam int IW = $clog2(NUM_SOURCES);

    irq_wake_pkg::state_t st;
    irq_wake_pkg::state_t next_st;

    logic [NUM_SOURCES-1:0] pending;
    logic [NUM_SOURCES-1:0] enables;
    logic [NUM_SOURCES-1:0] allowed;
    logic [NUM_SOURCES-1:0] levelHigh;
    logic [NUM_SOURCES-1:0] levelLow;
    logic                   pickFound;
    logic [IW-1:0]          pickIndex;
    logic [1:0]             pickLevel;
    logic                   ackNow;
    logic                   wrHit;

    // Vector address of a source index; slot 0033 has no source
    function automatic logic [15:0] vectorOf(input logic [IW-1:0] idx);
        logic [15:0] v;
        v = `VEC_EXT_A;
        case (idx)
            4'd0:    v = `VEC_EXT_A;
            4'd1:    v = `VEC_TIMER_A;
            4'd2:    v = `VEC_EXT_B;
            4'd3:    v = `VEC_TIMER_B;
            4'd4:    v = `VEC_SERIAL;
            4'd5:    v = `VEC_TIMER_C;
            4'd6:    v = `VEC_TIMER_D;
            4'd7:    v = `VEC_PORT_CHANGE;
            4'd8:    v = `VEC_EXT_C;
            4'd9:    v = `VEC_CONVERT;
            4'd10:   v = `VEC_SPI;
            default: v = `VEC_DEBUG_EMU;
        endcase
        return v;
    endfunction

    // Highest level currently in service, and whether any is
    function automatic logic [2:0] activeTop(input logic [3:0] mask);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (mask[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    // Clears the highest level bit in service
    function automatic logic [3:0] dropTop(input logic [3:0] mask);
        logic [3:0] m;
        logic       done;
        m = mask;
        done = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i] && !done) begin
                m[i] = 1'b0;
                done = 1'b1;
            end
        end
        return m;
    endfunction

    // Pending sources in ascending vector order
    always_comb begin
        pending[0]  = st.extFlag[0];
        pending[1]  = timerAOverflow;
        pending[2]  = st.extFlag[1];
        pending[3]  = timerBOverflow;
        pending[4]  = uartRxFlag | uartTxFlag;
        pending[5]  = timerCOverflow | timerCExternalFlag;
        pending[6]  = timerDOverflow;
        pending[7]  = st.portFlag;
        pending[8]  = st.extFlag[2];
        pending[9]  = adcDoneFlag | touchDoneFlag;
        pending[10] = spiDoneFlag | spiCollisionFlag | spiFaultFlag;
    end

    // Per-source enables and levels gathered from both register groups
    assign enables   = {st.enExtra[4:0], st.enMain[5:0]};
    assign levelHigh = {st.prioHigh2, st.prioHigh};
    assign levelLow  = {st.prioLow2, st.prioLow};
    assign allowed   = pending & enables
                     & {NUM_SOURCES{st.enMain[`EN_GLOBAL_BIT]}};

    irq_priority_pick #(
        .NUM (NUM_SOURCES),
        .IW  (IW)
    ) u_pick (
        .req      (allowed),
        .prioHigh (levelHigh),
        .prioLow  (levelLow),
        .found    (pickFound),
        .index    (pickIndex),
        .level    (pickLevel)
    );

    assign ackNow = st.irqReq && irqAck;
    assign wrHit  = sfrWr;

    always_comb begin
        logic [2:0]            top;
        logic [PORT_WIDTH-1:0] change;
        logic                  fallA;
        logic                  fallB;
        logic                  fallC;
        logic [2:0]            ackTop;
        logic [3:0]            pinWake;
        next_st = st;
        top     = activeTop(st.activeMask);
        change  = (portPins ^ st.portPrev) & st.portWakeMask;
        fallA   = st.pinPrev[0] && !extPinA;
        fallB   = st.pinPrev[1] && !extPinB;
        fallC   = st.pinPrev[2] && !extPinC;
        ackTop  = activeTop(st.activeMask);
        pinWake = 4'h0;

        next_st.pinPrev    = {extPinC, extPinB, extPinA};
        next_st.portPrev   = portPins;
        next_st.portPrimed = 1'b1;

        // Register writes
        if (wrHit) begin
            case (sfrAddr)
                `ADDR_TRIG_CTRL: begin
                    next_st.trigType = {sfrWrData[`TRIG_B_TYPE_BIT],
                                        sfrWrData[`TRIG_A_TYPE_BIT]};
                    next_st.extFlag[0] = sfrWrData[`TRIG_A_FLAG_BIT];
                    next_st.extFlag[1] = sfrWrData[`TRIG_B_FLAG_BIT];
                end
                `ADDR_FLAG_EXTRA: begin
                    next_st.extFlag[2] = sfrWrData[`FLAG_EXT_C_BIT];
                    next_st.portFlag   = sfrWrData[`FLAG_PORT_BIT];
                end
                `ADDR_PORT_WAKE:  next_st.portWakeMask = sfrWrData;
                `ADDR_EN_MAIN:    next_st.enMain = sfrWrData & `EN_MAIN_MASK;
                `ADDR_EN_EXTRA:   next_st.enExtra = sfrWrData & `EN_EXTRA_MASK;
                `ADDR_PRIO_LOW:   next_st.prioLow = sfrWrData[5:0] & `PRIO_MASK;
                `ADDR_PRIO_HIGH:  next_st.prioHigh = sfrWrData[5:0] & `PRIO_MASK;
                `ADDR_PRIO_LOW2:  next_st.prioLow2 = sfrWrData[4:0] & `PRIO2_MASK;
                `ADDR_PRIO_HIGH2: next_st.prioHigh2 = sfrWrData[4:0] & `PRIO2_MASK;
                default: begin
                end
            endcase
        end

        // Taken request: mark level in service, clear edge pin flags
        if (ackNow) begin
            next_st.activeMask[pickLevel] = 1'b1;
            if (pickIndex == IW'(0) && st.trigType[0]) begin
                next_st.extFlag[0] = 1'b0;
            end
            if (pickIndex == IW'(2) && st.trigType[1]) begin
                next_st.extFlag[1] = 1'b0;
            end
            if (pickIndex == IW'(8)) begin
                next_st.extFlag[2] = 1'b0;
            end
        end else if (irqReturn) begin
            next_st.activeMask = dropTop(st.activeMask);
        end

        // Events set flags last so a set beats a same-cycle clear
        if (st.trigType[0]) begin
            if (fallA) begin
                next_st.extFlag[0] = 1'b1;
            end
        end else begin
            next_st.extFlag[0] = !extPinA;
        end
        if (st.trigType[1]) begin
            if (fallB) begin
                next_st.extFlag[1] = 1'b1;
            end
        end else begin
            next_st.extFlag[1] = !extPinB;
        end
        if (fallC) begin
            next_st.extFlag[2] = 1'b1;
        end
        if (st.portPrimed && |change) begin
            next_st.portFlag = 1'b1;
        end

        // Request when winner is above every level in service
        next_st.irqReq = pickFound && !ackNow
                         && (!top[2] || pickLevel > top[1:0]);
        if (pickFound) begin
            next_st.irqVector = vectorOf(pickIndex);
        end
        if (ackTop[2] && ackNow) begin
            next_st.irqReq = 1'b0;
        end

        // Wake-up
        next_st.wakeIdle = idleMode && |allowed;
        pinWake[0] = st.extFlag[0] && st.enMain[0];
        pinWake[1] = st.extFlag[1] && st.enMain[2];
        pinWake[2] = st.extFlag[2] && st.enExtra[2];
        pinWake[3] = st.portFlag && st.enExtra[1];
        next_st.wakeStop = stopMode && |pinWake;

        // Read data, one cycle after the strobe
        next_st.rdData = 8'h00;
        if (sfrRd) begin
            case (sfrAddr)
                `ADDR_TRIG_CTRL: begin
                    next_st.rdData[`TRIG_A_TYPE_BIT] = st.trigType[0];
                    next_st.rdData[`TRIG_A_FLAG_BIT] = st.extFlag[0];
                    next_st.rdData[`TRIG_B_TYPE_BIT] = st.trigType[1];
                    next_st.rdData[`TRIG_B_FLAG_BIT] = st.extFlag[1];
                end
                `ADDR_FLAG_EXTRA: begin
                    next_st.rdData[`FLAG_EXT_C_BIT] = st.extFlag[2];
                    next_st.rdData[`FLAG_PORT_BIT]  = st.portFlag;
                end
                `ADDR_PORT_WAKE:  next_st.rdData = st.portWakeMask;
                `ADDR_EN_MAIN:    next_st.rdData = st.enMain;
                `ADDR_EN_EXTRA:   next_st.rdData = st.enExtra;
                `ADDR_PRIO_LOW:   next_st.rdData = {2'h0, st.prioLow};
                `ADDR_PRIO_HIGH:  next_st.rdData = {2'h0, st.prioHigh};
                `ADDR_PRIO_LOW2:  next_st.rdData = {3'h0, st.prioLow2};
                `ADDR_PRIO_HIGH2: next_st.rdData = {3'h0, st.prioHigh2};
                default:          next_st.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st              <= '0;
            st.portWakeMask <= `RST_BYTE;
            st.enMain       <= `RST_BYTE;
            st.enExtra      <= `RST_BYTE;
            st.pinPrev      <= `RST_PIN_PREV;
            st.irqVector    <= `VEC_EXT_A;
        end else begin
            st <= next_st;
        end
    end

    assign sfrRdData    = st.rdData;
    assign irqReq       = st.irqReq;
    assign irqVector    = st.irqVector;
    assign wakeIdle     = st.wakeIdle;
    assign wakeStop     = st.wakeStop;
    assign flashWriteEn = st.enExtra[`EN_FLASH_BIT];

endmodule

`default_nettype wire

/* File: hdl/irq_priority_pick.sv */
// Picks the winning pending source: highest level, then lowest index.
// Assumes sources are numbered in ascending vector order.
`timescale 1ns/1ps
`default_nettype none

module irq_priority_pick #(
    parameter int NUM = 11,
    parameter int IW  = 4
) (
    input  wire logic [NUM-1:0] req,
    input  wire logic [NUM-1:0] prioHigh,
    input  wire logic [NUM-1:0] prioLow,
    output var  logic           found,
    output var  logic [IW-1:0]  index,
    output var  logic [1:0]     level
);

    // Level code is the high bit over the low bit
    always_comb begin
        found = 1'b0;
        index = '0;
        level = 2'h0;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (req[i] && (!found || {prioHigh[i], prioLow[i]} >= level))
            begin
                found = 1'b1;
                index = IW'(i);
                level = {prioHigh[i], prioLow[i]};
            end
        end
    end

endmodule

`default_nettype wire

/* File: hdl/irq_wake_cfg.svh */
// Addresses, field positions, reset values and vectors of the
// interrupt and wake-up controller.
// Assumes an 8-bit special-register space driven by the CPU core.
`ifndef IRQ_WAKE_CFG_SVH
`define IRQ_WAKE_CFG_SVH

// Register addresses
`define ADDR_TRIG_CTRL   8'h88
`define ADDR_FLAG_EXTRA  8'h95
`define ADDR_PORT_WAKE   8'h96
`define ADDR_EN_MAIN     8'ha8
`define ADDR_EN_EXTRA    8'ha9
`define ADDR_PRIO_LOW    8'hb8
`define ADDR_PRIO_HIGH   8'hb9
`define ADDR_PRIO_LOW2   8'hba
`define ADDR_PRIO_HIGH2  8'hbb

// Field positions
`define TRIG_A_TYPE_BIT  0
`define TRIG_A_FLAG_BIT  1
`define TRIG_B_TYPE_BIT  2
`define TRIG_B_FLAG_BIT  3
`define FLAG_PORT_BIT    1
`define FLAG_EXT_C_BIT   2
`define EN_GLOBAL_BIT    7
`define EN_FLASH_BIT     6

// Writable masks
`define EN_MAIN_MASK     8'hbf
`define EN_EXTRA_MASK    8'h5f
`define PRIO_MASK        6'h3f
`define PRIO2_MASK       5'h1f

// Reset values
`define RST_BYTE         8'h00
`define RST_PIN_PREV     3'h7

// Vector addresses, in source index order
`define VEC_EXT_A        16'h0003
`define VEC_TIMER_A      16'h000b
`define VEC_EXT_B        16'h0013
`define VEC_TIMER_B      16'h001b
`define VEC_SERIAL       16'h0023
`define VEC_TIMER_C      16'h002b
`define VEC_DEBUG_EMU    16'h0033
`define VEC_TIMER_D      16'h003b
`define VEC_PORT_CHANGE  16'h0043
`define VEC_EXT_C        16'h004b
`define VEC_CONVERT      16'h0053
`define VEC_SPI          16'h005b

`endif

/* File: hdl/irq_wake_pkg.sv */
// Types of the interrupt and wake-up controller.
// Assumes the constants of irq_wake_cfg.svh for values.
package irq_wake_pkg;

    // Complete register state of the controller
    typedef struct packed {
        logic [7:0]  portWakeMask;
        logic [7:0]  enMain;
        logic [7:0]  enExtra;
        logic [5:0]  prioLow;
        logic [5:0]  prioHigh;
        logic [4:0]  prioLow2;
        logic [4:0]  prioHigh2;
        logic [1:0]  trigType;
        logic [2:0]  extFlag;
        logic        portFlag;
        logic [2:0]  pinPrev;
        logic [7:0]  portPrev;
        logic        portPrimed;
        logic [3:0]  activeMask;
        logic        irqReq;
        logic [15:0] irqVector;
        logic        wakeIdle;
        logic        wakeStop;
        logic [7:0]  rdData;
    } state_t;

endpackage

/* File: verif/cpu_core_model.sv */
// CPU core model: takes a request after a chosen number of cycles.
// Assumes irqReq is held until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ackOn,
    input  wire logic [3:0]  ackDelay,
    input  wire logic        irqReq,
    input  wire logic [15:0] irqVector,
    output var  logic        irqAck,
    output var  logic [15:0] takenVec,
    output var  logic [7:0]  takenCnt
);
    logic [3:0] waitCnt;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irqAck   <= 1'b0;
            waitCnt  <= 4'h0;
            takenCnt <= 8'h00;
            takenVec <= 16'h0000;
        end else if (irqAck) begin
            irqAck   <= 1'b0;
            waitCnt  <= 4'h0;
            takenVec <= irqVector;
            takenCnt <= takenCnt + 8'h01;
        end else if (irqReq && ackOn) begin
            if (waitCnt == ackDelay)
                irqAck <= 1'b1;
            else
                waitCnt <= waitCnt + 4'h1;
        end else begin
            waitCnt <= 4'h0;
        end
    end
endmodule
`default_nettype wire

/* File: verif/irq_wake_monitor.sv */
// Checker of the interrupt controller, bound to its top ports.
// Assumes register writes land at the edge that samples sfrWr.
`timescale 1ns/1ps
`default_nettype none
module irq_wake_monitor #(
    parameter int NUM_SOURCES = 11,
    parameter int PORT_WIDTH  = 8
) (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [7:0]  sfrAddr,
    input wire logic [7:0]  sfrWrData,
    input wire logic        sfrWr,
    input wire logic        sfrRd,
    input wire logic [7:0]  sfrRdData,
    input wire logic        idleMode,
    input wire logic        stopMode,
    input wire logic        irqAck,
    input wire logic        irqReq,
    input wire logic [15:0] irqVector,
    input wire logic        wakeIdle,
    input wire logic        wakeStop
);
    logic [7:0] enMain;
    logic [7:0] enExtra;
    logic [7:0] portMask;
    // Shadow copies of the enable registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            enMain   <= 8'h00;
            enExtra  <= 8'h00;
            portMask <= 8'h00;
        end else if (sfrWr) begin
            if (sfrAddr == 8'ha8) enMain <= sfrWrData & 8'hbf;
            if (sfrAddr == 8'ha9) enExtra <= sfrWrData & 8'h5f;
            if (sfrAddr == 8'h96) portMask <= sfrWrData;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    ack_drop_a: assert property (irqReq && irqAck |=> !irqReq)
        else $error("request held after acknowledge");
    global_gate_a: assert property (irqReq |-> $past(enMain[7]))
        else $error("request while global enable off");
    idle_wake_a: assert property
        ((!idleMode || !enMain[7]) |=> !wakeIdle)
        else $error("idle wake without cause");
    stop_wake_a: assert property (!stopMode |=> !wakeStop)
        else $error("stop wake outside stop");
    stop_src_a: assert property (wakeStop |->
        $past({enMain[0], enMain[2], enExtra[2:1]}) != 4'h0)
        else $error("stop wake without pin enable");
    vec_legal_a: assert property (irqReq |-> irqVector inside
        {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
         16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h005b})
        else $error("illegal vector");
    en_read_a: assert property (sfrRd && sfrAddr == 8'ha8
        |=> sfrRdData == $past(enMain))
        else $error("enable register readback");
    mask_read_a: assert property (sfrRd && sfrAddr == 8'h96
        |=> sfrRdData == $past(portMask))
        else $error("port mask readback");
endmodule

bind interrupt_wakeup_controller irq_wake_monitor #(
    .NUM_SOURCES(NUM_SOURCES), .PORT_WIDTH(PORT_WIDTH)) mon (
    .core_clk(core_clk), .nrst(nrst), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrRdData(sfrRdData), .idleMode(idleMode), .stopMode(stopMode),
    .irqAck(irqAck), .irqReq(irqReq), .irqVector(irqVector),
    .wakeIdle(wakeIdle), .wakeStop(wakeStop));
`default_nettype wire

/* File: verif/tb.sv */
// Bench of the interrupt controller: registers, vectors, nesting.
// Assumes the CPU core model acknowledges requests.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        core_clk, nrst, sfrWr, sfrRd, ackOn, irqReturn;
    logic        pinA, pinB, pinC, idleMode, stopMode;
    logic        irqAck, irqReq, wakeIdle, wakeStop, flashWriteEn;
    logic [3:0]  ackDelay;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData, portPins, takenCnt;
    logic [11:0] pf;
    logic [15:0] irqVector, takenVec;
    int          err_total, checks_done, cycles;
    localparam logic [15:0] VT [12] = '{16'h000b, 16'h001b, 16'h002b,
        16'h002b, 16'h003b, 16'h0023, 16'h0023, 16'h0053, 16'h0053,
        16'h005b, 16'h005b, 16'h005b};
    interrupt_wakeup_controller dut (
        .core_clk(core_clk), .nrst(nrst), .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
        .sfrRdData(sfrRdData), .extPinA(pinA), .extPinB(pinB),
        .extPinC(pinC), .portPins(portPins), .timerAOverflow(pf[0]),
        .timerBOverflow(pf[1]), .timerCOverflow(pf[2]),
        .timerCExternalFlag(pf[3]), .timerDOverflow(pf[4]),
        .uartRxFlag(pf[5]), .uartTxFlag(pf[6]), .adcDoneFlag(pf[7]),
        .touchDoneFlag(pf[8]), .spiDoneFlag(pf[9]),
        .spiCollisionFlag(pf[10]), .spiFaultFlag(pf[11]),
        .idleMode(idleMode), .stopMode(stopMode), .irqAck(irqAck),
        .irqReturn(irqReturn), .irqReq(irqReq), .irqVector(irqVector),
        .wakeIdle(wakeIdle), .wakeStop(wakeStop),
        .flashWriteEn(flashWriteEn));
    cpu_core_model cpu (.core_clk(core_clk), .nrst(nrst), .ackOn(ackOn),
        .ackDelay(ackDelay), .irqReq(irqReq), .irqVector(irqVector),
        .irqAck(irqAck), .takenVec(takenVec), .takenCnt(takenCnt));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {sfrWr, sfrAddr, sfrWrData} <= {1'b1, a, d};
        @(posedge core_clk);
        sfrWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        {sfrRd, sfrAddr} <= {1'b1, a};
        @(posedge core_clk);
        sfrRd <= 1'b0;
        #1 chk({8'h00, sfrRdData}, {8'h00, exp});
    endtask
    task automatic take(input logic [15:0] exp);
        logic [7:0] c;
        int n;
        c = takenCnt;
        for (n = 0; n < 60 && takenCnt === c; n++)
            tick(1);
        chk({8'h00, takenCnt}, {8'h00, c + 8'h01});
        chk(takenVec, exp);
    endtask
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            tick(1);
            seen = seen | irqReq;
        end
        chk({15'h0, seen}, 16'h0000);
    endtask
    task automatic pop();
        @(posedge core_clk);
        irqReturn <= 1'b1;
        @(posedge core_clk);
        irqReturn <= 1'b0;
    endtask
    task automatic ret();
        @(posedge core_clk);
        {pf, pinA, pinB, pinC} <= {12'h000, 3'h7};
        pop();
    endtask
    task automatic fire(input int i, input logic [15:0] exp);
        @(posedge core_clk);
        pf <= pf | (12'h001 << i);
        take(exp);
        @(posedge core_clk);
        pf <= 12'h000;
    endtask
    task automatic t_regs();
        rd(8'h96, 8'h00);
        rd(8'ha8, 8'h00);
        rd(8'ha9, 8'h00);
        wr(8'h96, 8'ha5);
        rd(8'h96, 8'ha5);
        wr(8'ha8, 8'hff);
        rd(8'ha8, 8'hbf);
        wr(8'ha9, 8'hff);
        rd(8'ha9, 8'h5f);
        chk({15'h0, flashWriteEn}, 16'h0001);
        wr(8'hba, 8'hff);
        rd(8'hba, 8'h1f);
        wr(8'hbb, 8'he4);
        rd(8'hbb, 8'h04);
        wr(8'hba, 8'h00);
        wr(8'hbb, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
    endtask
    task automatic t_sources();
        int i;
        for (i = 0; i < 12; i++) begin
            @(posedge core_clk);
            ackDelay <= i[3:0];
            pf <= 12'h001 << i;
            take(VT[i]);
            ret();
        end
    endtask
    task automatic t_pins();
        wr(8'h88, 8'h01);
        @(posedge core_clk);
        pinA <= 1'b0;
        take(16'h0003);
        ret();
        @(posedge core_clk);
        pinB <= 1'b0;
        take(16'h0013);
        ret();
        @(posedge core_clk);
        pinC <= 1'b0;
        take(16'h004b);
        ret();
        wr(8'h96, 8'h01);
        @(posedge core_clk);
        portPins <= 8'h02;
        quiet(8);
        @(posedge core_clk);
        portPins <= 8'h03;
        take(16'h0043);
        wr(8'h95, 8'h00);
        ret();
    endtask
    task automatic t_prio();
        wr(8'hb8, 8'h08);
        wr(8'hb9, 8'h10);
        fire(0, 16'h000b);
        fire(1, 16'h001b);
        fire(5, 16'h0023);
        @(posedge core_clk);
        pf[1] <= 1'b1;
        quiet(10);
        pop();
        quiet(6);
        pop();
        take(16'h001b);
        ret();
        pop();
        wr(8'hb8, 8'h00);
        wr(8'hb9, 8'h00);
        @(posedge core_clk);
        {ackOn, pf} <= {1'b0, 12'h023};
        tick(4);
        @(posedge core_clk);
        ackOn <= 1'b1;
        take(16'h000b);
        ret();
    endtask
    task automatic t_global();
        wr(8'ha8, 8'h3f);
        @(posedge core_clk);
        pf[0] <= 1'b1;
        quiet(10);
        wr(8'ha8, 8'hbf);
        take(16'h000b);
        ret();
        wr(8'ha8, 8'hbe);
        @(posedge core_clk);
        pinA <= 1'b0;
        quiet(6);
        rd(8'h88, 8'h03);
        @(posedge core_clk);
        pinA <= 1'b1;
        wr(8'h88, 8'h01);
    endtask
    task automatic t_wake();
        @(posedge core_clk);
        {ackOn, idleMode, pf[0]} <= 3'b011;
        tick(3);
        chk({15'h0, wakeIdle}, 16'h0001);
        @(posedge core_clk);
        {idleMode, stopMode} <= 2'b01;
        tick(3);
        chk({15'h0, wakeStop}, 16'h0000);
        wr(8'ha8, 8'h3f);
        wr(8'ha9, 8'h04);
        @(posedge core_clk);
        pinC <= 1'b0;
        tick(3);
        chk({15'h0, wakeStop}, 16'h0001);
        @(posedge core_clk);
        pinC <= 1'b1;
        wr(8'h95, 8'h00);
        wr(8'ha9, 8'h02);
        tick(1);
        chk({15'h0, wakeStop}, 16'h0000);
        @(posedge core_clk);
        portPins <= 8'h02;
        tick(3);
        chk({15'h0, wakeStop}, 16'h0001);
    endtask
    initial begin
        {nrst, sfrWr, sfrRd, ackOn, irqReturn, idleMode, stopMode} = '0;
        {pinA, pinB, pinC} = 3'h7;
        {sfrAddr, sfrWrData, portPins, ackDelay} = '0;
        pf = 12'h000;
        repeat (20) @(posedge core_clk);
        {nrst, ackOn} <= 2'b11;
        t_regs();
        t_sources();
        t_pins();
        t_prio();
        t_global();
        t_wake();
        complete_run();
    end
endmodule
`default_nettype wire
